// [src/azm_regs.sv]
`timescale 1ns/1ps
module azm_regs #(
    parameter int unsigned RUN_SHIFT = 0 // Shortens zero-run counts, 0 to 8
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [azm_pkg::ADDR_W-1:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic [azm_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_rd, // Read strobe, one cycle
    output logic [azm_pkg::DATA_W-1:0] reg_rdata, // Read data
    output logic reg_rvalid, // Read data valid, one cycle
    input wire logic sample_valid, // One-cycle strobe per stereo sample
    input wire logic [azm_pkg::SAMPLE_W-1:0] left_sample, // Left sample
    input wire logic [azm_pkg::SAMPLE_W-1:0] right_sample, // Right sample
    input wire logic [2:0] automute_en, // Auto-mute enables
    output logic left_zero_muted_flag, // Left auto-muted
    output logic right_zero_muted_flag, // Right auto-muted
    output logic [1:0] loop_bandwidth_sel, // Loop bandwidth code
    output logic pwm_in_phase, // 1 same phase, 0 opposite
    output logic [azm_pkg::TRIM_W-1:0] output_level_trim, // Gain trim code
    input wire logic [azm_pkg::DATA_W-1:0] supply_voltage_code, // ADC result
    input wire logic [3:0] pin0_function_code, // Pin 0 function code
    input wire logic warning_src_n, // Warning source, active low
    input wire logic fault_src_n, // Fault source, active low
    input wire logic serial_audio_src, // Serial audio data out
    input wire logic supply_drop_src, // Supply-drop flag
    input wire logic class_h_src, // Class-H control
    output logic [azm_pkg::NPIN-1:0] pin_out, // Pin levels, index 0..2
    output logic [azm_pkg::NPIN-1:0] pin_oe_n, // Pin enables, active low
    input wire logic [azm_pkg::NPIN-1:0] pin_in, // Pin pad inputs
    output logic [azm_pkg::NPIN-1:0] pin_level // Synchronised pin inputs
);
    import azm_pkg::*;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] zero_mute_delay;
    logic [7:0] amp_loop_config;
    logic [7:0] output_gain_trim;
    logic [7:0] supply_voltage_monitor;
    logic [7:0] pin_direction;
    logic [7:0] pin1_function_select;
    logic [7:0] pin2_function_select;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire hit_zmd = (reg_addr == OFS_ZERO_MUTE_DELAY);
    wire hit_loop = (reg_addr == OFS_AMP_LOOP_CONFIG);
    wire hit_trim = (reg_addr == OFS_OUTPUT_GAIN_TRIM);
    wire hit_supply = (reg_addr == OFS_SUPPLY_VOLTAGE_MONITOR);
    wire hit_dir = (reg_addr == OFS_PIN_DIRECTION);
    wire hit_pin1 = (reg_addr == OFS_PIN1_FUNCTION_SELECT);
    wire hit_pin2 = (reg_addr == OFS_PIN2_FUNCTION_SELECT);

    // Whole bytes are stored, so reserved bits read back what was written
    wire wr_zmd = reg_wr && hit_zmd;
    wire wr_loop = reg_wr && hit_loop;
    wire wr_trim = reg_wr && hit_trim;
    wire wr_dir = reg_wr && hit_dir;
    wire wr_pin1 = reg_wr && hit_pin1;
    wire wr_pin2 = reg_wr && hit_pin2;

    logic [7:0] next_rdata;
    assign next_rdata = hit_zmd ? zero_mute_delay :
                        hit_loop ? amp_loop_config :
                        hit_trim ? output_gain_trim :
                        hit_supply ? supply_voltage_monitor :
                        hit_dir ? pin_direction :
                        hit_pin1 ? pin1_function_select :
                        hit_pin2 ? pin2_function_select : READ_UNMAPPED;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            zero_mute_delay <= RST_ZERO_MUTE_DELAY;
            amp_loop_config <= RST_AMP_LOOP_CONFIG;
            output_gain_trim <= RST_OUTPUT_GAIN_TRIM;
            pin_direction <= RST_PIN_DIRECTION;
            pin1_function_select <= RST_PIN1_FUNCTION_SELECT;
            pin2_function_select <= RST_PIN2_FUNCTION_SELECT;
        end
        else
        begin
            if (wr_zmd) zero_mute_delay <= reg_wdata;
            if (wr_loop) amp_loop_config <= reg_wdata;
            if (wr_trim) output_gain_trim <= reg_wdata;
            if (wr_dir) pin_direction <= reg_wdata;
            if (wr_pin1) pin1_function_select <= reg_wdata;
            if (wr_pin2) pin2_function_select <= reg_wdata;
        end
    end

    // Supply code is refreshed from the converter every cycle and ignores writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            supply_voltage_monitor <= RST_SUPPLY_VOLTAGE_MONITOR;
        else
            supply_voltage_monitor <= supply_voltage_code;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= READ_UNMAPPED;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    // ----------------------------------------------------------------
    // Analog control outputs
    // ----------------------------------------------------------------
    assign loop_bandwidth_sel = amp_loop_config[BW_LSB +: 2];
    assign pwm_in_phase = amp_loop_config[PHASE_BIT];
    assign output_level_trim = output_gain_trim[TRIM_LSB +: TRIM_W];

    // ----------------------------------------------------------------
    // Zero-run detection
    // ----------------------------------------------------------------
    logic [RUN_W-1:0] left_threshold;
    logic [RUN_W-1:0] right_threshold;
    logic left_qualified;
    logic right_qualified;
    wire left_zero = (left_sample == '0);
    wire right_zero = (right_sample == '0);

    assign left_threshold = zr_threshold(zero_mute_delay[RUN_LEFT_LSB +: 3]) >> RUN_SHIFT;
    assign right_threshold = zr_threshold(zero_mute_delay[RUN_RIGHT_LSB +: 3]) >> RUN_SHIFT;

    azm_zero_run u_run_left (
        .clk(clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .sample_zero(left_zero),
        .threshold(left_threshold),
        .qualified(left_qualified)
    );

    azm_zero_run u_run_right (
        .clk(clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .sample_zero(right_zero),
        .threshold(right_threshold),
        .qualified(right_qualified)
    );

    // ----------------------------------------------------------------
    // Auto-mute decision
    // ----------------------------------------------------------------
    // In both-mode a channel waits for its partner even if that one is disabled
    wire both_ok_left = !automute_en[MUTE_EN_BOTH] || right_qualified;
    wire both_ok_right = !automute_en[MUTE_EN_BOTH] || left_qualified;
    wire next_left_mute = automute_en[MUTE_EN_LEFT] && left_qualified && both_ok_left;
    wire next_right_mute = automute_en[MUTE_EN_RIGHT] && right_qualified && both_ok_right;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            left_zero_muted_flag <= 1'b0;
            right_zero_muted_flag <= 1'b0;
        end
        else
        begin
            left_zero_muted_flag <= next_left_mute;
            right_zero_muted_flag <= next_right_mute;
        end
    end

    // ----------------------------------------------------------------
    // General pins
    // ----------------------------------------------------------------
    logic [3:0] pin_code [NPIN];
    logic [NPIN-1:0] pin_dir;
    logic [NPIN-1:0] pin_meta;

    assign pin_code[0] = pin0_function_code;
    assign pin_code[1] = pin1_function_select[FUNC_LSB +: 4];
    assign pin_code[2] = pin2_function_select[FUNC_LSB +: 4];
    // Direction bits are not in pin order
    assign pin_dir[0] = pin_direction[DIR_PIN0_BIT];
    assign pin_dir[1] = pin_direction[DIR_PIN1_BIT];
    assign pin_dir[2] = pin_direction[DIR_PIN2_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_pin
            azm_pin_mux u_mux (
                .clk(clk),
                .rst_n(rst_n),
                .function_code(pin_code[gi]),
                .drive_enable(pin_dir[gi]),
                .warning_src_n(warning_src_n),
                .fault_src_n(fault_src_n),
                .serial_audio_src(serial_audio_src),
                .supply_drop_src(supply_drop_src),
                .class_h_src(class_h_src),
                .pin_out(pin_out[gi]),
                .pin_oe_n(pin_oe_n[gi])
            );
        end
    endgenerate

    // Pads are asynchronous to clk
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_meta <= '0;
            pin_level <= '0;
        end
        else
        begin
            pin_meta <= pin_in;
            pin_level <= pin_meta;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_left_threshold: assert property (
        zero_mute_delay[6:4] == 3'b000 |-> left_threshold == (19'd1104 >> RUN_SHIFT))
        else $error("left threshold not from bits 6-4");
    a_right_independent: assert property (
        $changed(zero_mute_delay[6:4]) && $stable(zero_mute_delay[2:0])
        |-> $stable(right_threshold))
        else $error("right threshold moved with left code");
    a_longest_code: assert property (
        zero_mute_delay[6:4] == 3'b111 |-> left_threshold == (19'd511680 >> RUN_SHIFT))
        else $error("code 111 does not give 5.33 s at 96 kHz");
    a_reserved_rw: assert property (
        wr_zmd ##1 (reg_rd && hit_zmd && !reg_wr) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("reserved bits not stored");
    a_bw_write: assert property (
        wr_loop |=> loop_bandwidth_sel == $past(reg_wdata[6:5]))
        else $error("bandwidth field not taken from bits 6-5");
    a_phase_write: assert property (
        wr_loop |=> pwm_in_phase == $past(reg_wdata[0]))
        else $error("phase bit not taken from bit 0");
    a_trim_write: assert property (
        wr_trim |=> output_level_trim == $past(reg_wdata[4:0]))
        else $error("gain trim not taken from bits 4-0");
    a_supply_readonly: assert property (
        reg_rd && hit_supply |=> reg_rdata == $past(supply_voltage_monitor) && reg_rvalid)
        else $error("supply code read wrong");
    a_dir_enable: assert property (
        wr_dir |=> ##1 pin_oe_n[0] == !$past(reg_wdata[2], 2)
        && pin_oe_n[2] == !$past(reg_wdata[1], 2) && pin_oe_n[1] == !$past(reg_wdata[0], 2))
        else $error("pin direction bit map wrong");
    a_mute_enable: assert property (
        left_zero_muted_flag |-> $past(automute_en[0]) && $past(left_qualified)
        && (!$past(automute_en[2]) || $past(right_qualified)))
        else $error("left muted without enable or partner");
    a_mute_flag: assert property (
        right_zero_muted_flag |-> $past(automute_en[1]) && $past(right_qualified))
        else $error("right flag set without qualifying run");
    a_nonzero_release: assert property (
        sample_valid && !left_zero |-> ##2 !left_zero_muted_flag)
        else $error("nonzero sample did not release left mute");
    a_unmapped_zero: assert property (
        reg_rd && !(hit_zmd || hit_loop || hit_trim || hit_supply || hit_dir
        || hit_pin1 || hit_pin2) |=> reg_rdata == READ_UNMAPPED)
        else $error("unmapped read not zero");

    c_left_mute: cover property ($rose(left_zero_muted_flag));
    c_both_mute: cover property (automute_en[2] && $rose(right_zero_muted_flag));
    c_release: cover property ($fell(left_zero_muted_flag));
    c_pin_drive: cover property (!pin_oe_n[1] && pin_out[1]);

endmodule : azm_regs

// [src/azm_pkg.sv]
package azm_pkg;

    // ----------------------------------------------------------------
    // Register port and sample widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 24;
    localparam int RUN_W = 19;
    localparam int NPIN = 3;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_ZERO_MUTE_DELAY = 8'h51;
    localparam logic [7:0] OFS_AMP_LOOP_CONFIG = 8'h53;
    localparam logic [7:0] OFS_OUTPUT_GAIN_TRIM = 8'h54;
    localparam logic [7:0] OFS_SUPPLY_VOLTAGE_MONITOR = 8'h5E;
    localparam logic [7:0] OFS_PIN_DIRECTION = 8'h60;
    localparam logic [7:0] OFS_PIN1_FUNCTION_SELECT = 8'h61;
    localparam logic [7:0] OFS_PIN2_FUNCTION_SELECT = 8'h62;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ZERO_MUTE_DELAY = 8'h00;
    localparam logic [7:0] RST_AMP_LOOP_CONFIG = 8'h00;
    localparam logic [7:0] RST_OUTPUT_GAIN_TRIM = 8'h00;
    localparam logic [7:0] RST_SUPPLY_VOLTAGE_MONITOR = 8'h00;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
    localparam logic [7:0] RST_PIN1_FUNCTION_SELECT = 8'h00;
    localparam logic [7:0] RST_PIN2_FUNCTION_SELECT = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RUN_LEFT_LSB = 4;
    localparam int RUN_RIGHT_LSB = 0;
    localparam int BW_LSB = 5;
    localparam int PHASE_BIT = 0;
    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 5;
    localparam int DIR_PIN0_BIT = 2;
    localparam int DIR_PIN2_BIT = 1;
    localparam int DIR_PIN1_BIT = 0;
    localparam int FUNC_LSB = 0;
    localparam int MUTE_EN_LEFT = 0;
    localparam int MUTE_EN_RIGHT = 1;
    localparam int MUTE_EN_BOTH = 2;

    // ----------------------------------------------------------------
    // Pin function codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        AZM_FN_LOW = 4'b0000,
        AZM_FN_WARN = 4'b1000,
        AZM_FN_SERIAL = 4'b1001,
        AZM_FN_FAULT = 4'b1011,
        AZM_FN_SUPPLY_DROP = 4'b1100,
        AZM_FN_CLASS_H = 4'b1101
    } azm_pin_fn_t;

    // ----------------------------------------------------------------
    // Zero-run delays at the reference sample rate
    // ----------------------------------------------------------------
    localparam longint SAMPLE_RATE_HZ = 96000;
    localparam longint US_PER_S = 1000000;
    localparam longint ZR_TIME_US_0 = 11500;
    localparam longint ZR_TIME_US_1 = 53000;
    localparam longint ZR_TIME_US_2 = 106500;
    localparam longint ZR_TIME_US_3 = 266500;
    localparam longint ZR_TIME_US_4 = 535000;
    localparam longint ZR_TIME_US_5 = 1065000;
    localparam longint ZR_TIME_US_6 = 2665000;
    localparam longint ZR_TIME_US_7 = 5330000;
    localparam logic [18:0] ZR_CNT_0 = 19'(ZR_TIME_US_0 * SAMPLE_RATE_HZ / US_PER_S);
    localparam logic [18:0] ZR_CNT_1 = 19'(ZR_TIME_US_1 * SAMPLE_RATE_HZ / US_PER_S);
    localparam logic [18:0] ZR_CNT_2 = 19'(ZR_TIME_US_2 * SAMPLE_RATE_HZ / US_PER_S);
    localparam logic [18:0] ZR_CNT_3 = 19'(ZR_TIME_US_3 * SAMPLE_RATE_HZ / US_PER_S);
    localparam logic [18:0] ZR_CNT_4 = 19'(ZR_TIME_US_4 * SAMPLE_RATE_HZ / US_PER_S);
    localparam logic [18:0] ZR_CNT_5 = 19'(ZR_TIME_US_5 * SAMPLE_RATE_HZ / US_PER_S);
    localparam logic [18:0] ZR_CNT_6 = 19'(ZR_TIME_US_6 * SAMPLE_RATE_HZ / US_PER_S);
    localparam logic [18:0] ZR_CNT_7 = 19'(ZR_TIME_US_7 * SAMPLE_RATE_HZ / US_PER_S);

    // Zero-run code to a count of samples
    function automatic logic [18:0] zr_threshold(input logic [2:0] code);
        logic [18:0] cnt;
        cnt = ZR_CNT_0;
        case (code)
            3'h0: cnt = ZR_CNT_0;
            3'h1: cnt = ZR_CNT_1;
            3'h2: cnt = ZR_CNT_2;
            3'h3: cnt = ZR_CNT_3;
            3'h4: cnt = ZR_CNT_4;
            3'h5: cnt = ZR_CNT_5;
            3'h6: cnt = ZR_CNT_6;
            default: cnt = ZR_CNT_7;
        endcase
        return cnt;
    endfunction : zr_threshold

endpackage : azm_pkg

// [src/azm_zero_run.sv]
`timescale 1ns/1ps
module azm_zero_run (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic sample_valid, // One-cycle strobe per sample
    input wire logic sample_zero, // Current sample is all zero
    input wire logic [azm_pkg::RUN_W-1:0] threshold, // Samples needed
    output logic qualified // Run has reached threshold
);
    import azm_pkg::*;

    logic [RUN_W-1:0] run_count;
    logic [RUN_W-1:0] next_count;
    wire run_full = &run_count;

    // ----------------------------------------------------------------
    // Sample counting
    // ----------------------------------------------------------------
    // Counts samples, not clocks, so the delay follows the sample rate
    // Saturates instead of wrapping so a long silence never re-arms
    assign next_count = !sample_valid ? run_count :
                        !sample_zero ? '0 :
                        run_full ? run_count : run_count + 1'b1;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            run_count <= '0;
            qualified <= 1'b0;
        end
        else
        begin
            run_count <= next_count;
            qualified <= (next_count >= threshold);
        end
    end

    a_nonzero_clears: assert property (@(posedge clk) disable iff (!rst_n)
        sample_valid && !sample_zero |=> !qualified && run_count == '0)
        else $error("nonzero sample did not clear run");

endmodule : azm_zero_run

// [src/azm_pin_mux.sv]
`timescale 1ns/1ps
module azm_pin_mux (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [3:0] function_code, // Selected pin function
    input wire logic drive_enable, // 1 makes the pin an output
    input wire logic warning_src_n, // Warning source, active low
    input wire logic fault_src_n, // Fault source, active low
    input wire logic serial_audio_src, // Serial audio data out
    input wire logic supply_drop_src, // Supply-drop flag
    input wire logic class_h_src, // Class-H control
    output logic pin_out, // Pin output level
    output logic pin_oe_n // Output enable, active low
);
    import azm_pkg::*;

    logic next_out;

    // ----------------------------------------------------------------
    // Function select
    // ----------------------------------------------------------------
    // Unlisted codes fall back to a driven low
    assign next_out = (function_code == AZM_FN_WARN) ? warning_src_n :
                      (function_code == AZM_FN_SERIAL) ? serial_audio_src :
                      (function_code == AZM_FN_FAULT) ? fault_src_n :
                      (function_code == AZM_FN_SUPPLY_DROP) ? supply_drop_src :
                      (function_code == AZM_FN_CLASS_H) ? class_h_src : 1'b0;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end
        else
        begin
            pin_out <= next_out;
            pin_oe_n <= !drive_enable;
        end
    end

    a_fault_select: assert property (@(posedge clk) disable iff (!rst_n)
        function_code == AZM_FN_FAULT |=> pin_out == $past(fault_src_n))
        else $error("fault function not routed to pin");
    a_unlisted_low: assert property (@(posedge clk) disable iff (!rst_n)
        !(function_code inside {AZM_FN_WARN, AZM_FN_SERIAL, AZM_FN_FAULT,
        AZM_FN_SUPPLY_DROP, AZM_FN_CLASS_H}) |=> !pin_out)
        else $error("unlisted function code did not drive low");

endmodule : azm_pin_mux

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
    import azm_pkg::*;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sample_valid = 0, pwm_in_phase;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, supply_voltage_code = 0;
    logic [23:0] left_sample = 24'h00_0001, right_sample = 24'h00_0000;
    logic [3:0] pin0_function_code = 4'h0;
    logic fault_src_n = 1'b1;
    logic [2:0] automute_en = 0, pin_out, pin_oe_n, pin_level, pin_in = 3'b101;
    logic [1:0] loop_bandwidth_sel;
    logic [4:0] output_level_trim;
    logic reg_rvalid, left_zero_muted_flag, right_zero_muted_flag;
    logic [7:0] offs [7] = '{OFS_ZERO_MUTE_DELAY, OFS_AMP_LOOP_CONFIG, OFS_OUTPUT_GAIN_TRIM,
        OFS_PIN_DIRECTION, OFS_PIN1_FUNCTION_SELECT, OFS_PIN2_FUNCTION_SELECT, 8'h52};
    logic [3:0] codes [7] = '{4'h0, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'h3};
    logic [6:0] fn_exp = 7'b0101110;
    int err_total = 0, tests_run = 0;
    azm_regs #(.RUN_SHIFT(8)) u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .left_sample(left_sample),
        .right_sample(right_sample), .automute_en(automute_en),
        .left_zero_muted_flag(left_zero_muted_flag),
        .right_zero_muted_flag(right_zero_muted_flag), .loop_bandwidth_sel(loop_bandwidth_sel),
        .pwm_in_phase(pwm_in_phase), .output_level_trim(output_level_trim),
        .supply_voltage_code(supply_voltage_code), .pin0_function_code(pin0_function_code),
        .warning_src_n(1'b1), .fault_src_n(fault_src_n), .serial_audio_src(1'b1),
        .supply_drop_src(1'b0), .class_h_src(1'b1), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_in(pin_in), .pin_level(pin_level));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, e);
    endtask : rd
    task automatic samp(input logic [23:0] l, input logic [23:0] r, input int n,
        input logic [2:0] m, input logic [1:0] e);
        repeat (n)
        begin
            @(posedge clk);
            sample_valid <= 1;
            left_sample <= l;
            right_sample <= r;
            automute_en <= m;
        end
        @(posedge clk);
        sample_valid <= 0;
        @(posedge clk);
        #1 chk({6'h00, left_zero_muted_flag, right_zero_muted_flag}, {6'h00, e});
    endtask : samp
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 7; i++) rd(offs[i], 8'h00);
        chk({5'h00, pin_oe_n}, 8'h07);
        chk({5'h00, pin_level}, 8'h05);
        for (int i = 0; i < 6; i++)
        begin
            wr(offs[i], 8'hFF);
            rd(offs[i], 8'hFF);
        end
        chk({pwm_in_phase, loop_bandwidth_sel, output_level_trim}, 8'hFF);
        wr(OFS_SUPPLY_VOLTAGE_MONITOR, 8'h33);
        supply_voltage_code <= 8'hA5;
        rd(OFS_SUPPLY_VOLTAGE_MONITOR, 8'hA5);
        wr(OFS_AMP_LOOP_CONFIG, 8'h40);
        wr(OFS_OUTPUT_GAIN_TRIM, 8'hEA);
        #1 chk({pwm_in_phase, loop_bandwidth_sel, output_level_trim}, 8'h4A);
        // Widest loop bandwidth, the setting meant for the fast switching rate
        wr(OFS_AMP_LOOP_CONFIG, 8'h61);
        #1 chk({pwm_in_phase, loop_bandwidth_sel, output_level_trim}, 8'hEA);
    endtask : t_regs
    task automatic t_pins;
        wr(OFS_PIN_DIRECTION, 8'h06);
        pin_in <= 3'b010;
        repeat (2) @(posedge clk);
        #1 chk({5'h00, pin_oe_n}, 8'h02);
        chk({5'h00, pin_level}, 8'h02);
        for (int i = 0; i < 7; i++)
        begin
            wr(OFS_PIN1_FUNCTION_SELECT, {4'hF, codes[i]});
            wr(OFS_PIN2_FUNCTION_SELECT, {4'h0, codes[i]});
            pin0_function_code <= codes[i];
            repeat (2) @(posedge clk);
            #1 chk({5'h00, pin_out}, {5'h00, {3{fn_exp[i]}}});
        end
    endtask : t_pins
    task automatic t_mute;
        wr(OFS_ZERO_MUTE_DELAY, 8'h18);
        samp(24'h00_0000, 24'h00_0000, 3, 3'b011, 2'b00);
        samp(24'h00_0000, 24'h00_0000, 1, 3'b011, 2'b01);
        samp(24'h00_0000, 24'h00_0000, 15, 3'b011, 2'b11);
        samp(24'h00_0000, 24'h00_0000, 1, 3'b000, 2'b00);
        samp(24'h80_0000, 24'h00_0000, 1, 3'b011, 2'b01);
        // Both-mode: a qualified right run waits for the left one
        samp(24'h00_0000, 24'h00_0000, 1, 3'b111, 2'b00);
        samp(24'h00_0000, 24'h00_0000, 18, 3'b111, 2'b11);
        samp(24'h00_0000, 24'h00_0001, 1, 3'b111, 2'b00);
    endtask : t_mute
    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100_000;
        err_total++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        t_regs();
        t_pins();
        t_mute();
        print_verdict();
    end
endmodule : tb
